// ### src/dssr_pkg.sv
// Package of constants and carrier types for the drive stop and ramp sequencer
// Overview of operation
// - Decel mode: 0 standard, 1 fast
// - Standard mode: freeze decel while braking on
// - Standard mode: resume decel when braking off
// - Fast mode: decel ignores braking transistor
// - Stop mode 0 coast,1 ramp,2 ramp+inject,3 inject
// - Coast stop disables output at once
// - After coast, re-enable blocked one second
// - Ramp stop: disable one second after zero
// - Ramp+inject: one second DC injection at zero
// - Timed injection starts immediately, programmed duration
// - Control select: 0 frequency, 1 torque
// - Torque: target 120% max, clipped to limit
// - Direction from frequency sign, power flow from signs
// - Two skip frequencies, each with own band
// - Skip frequency zero disables its band
// - Skip region is plus/minus band, default 0.5
// - Ramp passes through skip regions without dwelling
// - Analogue input: 0 voltage, 1 thermistor
// - Upper limit 240/480/720/960 Hz by switching frequency
package dssr_pkg;
   // Frequencies are signed tenths of a hertz
   localparam int FREQ_W = 16;
   localparam logic [0:0] DECEL_STANDARD     = 1'h0;
   localparam logic [0:0] DECEL_FAST         = 1'h1;
   localparam logic [1:0] STOP_COAST         = 2'h0;
   localparam logic [1:0] STOP_RAMP          = 2'h1;
   localparam logic [1:0] STOP_RAMP_INJECT   = 2'h2;
   localparam logic [1:0] STOP_TIMED_INJECT  = 2'h3;
   localparam logic [0:0] CTRL_FREQUENCY     = 1'h0;
   localparam logic [0:0] CTRL_TORQUE        = 1'h1;
   localparam logic [0:0] AIN_VOLTAGE        = 1'h0;
   localparam logic [0:0] AIN_THERMISTOR     = 1'h1;
   // Reset values of the settings
   localparam logic [0:0] DECEL_MODE_RESET   = DECEL_STANDARD;
   localparam logic [1:0] STOP_MODE_RESET    = STOP_RAMP;
   localparam logic [0:0] CTRL_SEL_RESET     = CTRL_FREQUENCY;
   localparam logic [0:0] AIN_MODE_RESET     = AIN_VOLTAGE;
   localparam logic [FREQ_W-1:0] SKIP_FREQ_RESET = 16'h0000;
   localparam logic [FREQ_W-1:0] SKIP_BAND_RESET = 16'h0005; // 0.5 Hz
   // Upper limit frequency per switching frequency code, in tenths of Hz
   localparam logic [FREQ_W-1:0] UPPER_LIMIT_3K  = 16'h0960;  // 240.0 Hz
   localparam logic [FREQ_W-1:0] UPPER_LIMIT_6K  = 16'h12c0;  // 480.0 Hz
   localparam logic [FREQ_W-1:0] UPPER_LIMIT_9K  = 16'h1c20;  // 720.0 Hz
   localparam logic [FREQ_W-1:0] UPPER_LIMIT_12K = 16'h2580;  // 960.0 Hz
   // Timing
   localparam int CLK_HZ     = 10_000_000;
   localparam int HOLD_MS    = 1000;
   localparam int HOLD_TICKS = (CLK_HZ / 1000) * HOLD_MS;
   // Sequencer states
   typedef enum logic [5:0] {
      DSSR_IDLE   = 6'b000001,
      DSSR_RUN    = 6'b000010,
      DSSR_DECEL  = 6'b000100,
      DSSR_ZHOLD  = 6'b001000,
      DSSR_INJECT = 6'b010000,
      DSSR_LOCK   = 6'b100000
   } dssr_state_t;
   // Settings written by operator or serial side
   typedef struct packed {
      logic [0:0]        decel_ramp_mode;
      logic [1:0]        stop_sequence_mode;
      logic [0:0]        torque_control_select;
      logic [0:0]        analogue_input_mode;
      logic [1:0]        switch_freq_sel;
      logic [FREQ_W-1:0] skip_freq_1;
      logic [FREQ_W-1:0] skip_band_1;
      logic [FREQ_W-1:0] skip_freq_2;
      logic [FREQ_W-1:0] skip_band_2;
   } dssr_cfg_t;
   // Outputs toward the output stage
   typedef struct packed {
      logic                     output_enable;
      logic                     dc_inject;
      logic                     ramp_frozen;
      logic                     reverse;
      logic                     regenerating;
      logic                     thermistor_input_mode;
      logic                     stop_busy;
      logic signed [FREQ_W-1:0] freq;
   } dssr_out_t;
endpackage : dssr_pkg

// ### src/dssr_skip_band.sv
// One skip band: membership test and nearer-boundary hold value
`timescale 1ns/1ps
`default_nettype none
module dssr_skip_band
   import dssr_pkg::*;
#(
   parameter int W = FREQ_W
) (
   input  wire logic [W-1:0] mag_in,
   input  wire logic [W-1:0] skip_in,
   input  wire logic [W-1:0] band_in,
   output logic              inside_out,
   output logic [W-1:0]      edge_out
);
   logic [W:0] low;
   logic [W:0] high;
   // Widened by one bit so a band near full scale cannot wrap; a band reaching below zero clamps low to zero
   always_comb begin
      low  = {1'b0, skip_in} - {1'b0, band_in};
      high = {1'b0, skip_in} + {1'b0, band_in};
      if (band_in > skip_in) begin
         low = '0;
      end
      inside_out = (skip_in != '0) && ({1'b0, mag_in} > low) && ({1'b0, mag_in} < high);
      // Pick the boundary nearer the setpoint
      if (({1'b0, mag_in} - low) <= (high - {1'b0, mag_in})) begin
         edge_out = low[W-1:0];
      end else begin
         edge_out = high[W-1:0];
      end
   end
endmodule : dssr_skip_band
`default_nettype wire

// ### src/dssr_sequencer.sv
// Stop sequence, deceleration, skip bands and torque direction control
`timescale 1ns/1ps
`default_nettype none
module dssr_sequencer
   import dssr_pkg::*;
#(
   parameter int HOLD_CYCLES = HOLD_TICKS,
   parameter int RATE_DIV    = 1000
) (
   input  wire logic                     clk_in,
   input  wire logic                     rst_b_in,
   input  wire dssr_cfg_t                cfg_in,
   input  wire logic                     cfg_we_in,
   input  wire logic                     run_in,
   input  wire logic signed [FREQ_W-1:0] freq_ref_in,
   input  wire logic [FREQ_W-1:0]        max_freq_in,
   input  wire logic [FREQ_W-1:0]        accel_step_in,
   input  wire logic [FREQ_W-1:0]        decel_step_in,
   input  wire logic [31:0]              inject_cycles_in,
   input  wire logic                     brake_on_in,
   input  wire logic                     current_limit_in,
   input  wire logic                     torque_demand_high_in,
   input  wire logic                     torque_negative_in,
   output dssr_cfg_t                     cfg_out,
   output dssr_out_t                     drive_out,
   output logic                          pi_active_out
);
   // All state of the module in one record
   typedef struct packed {
      dssr_cfg_t                cfg;
      dssr_state_t              st;
      logic [31:0]              timer;
      logic [31:0]              rate_cnt;
      logic signed [FREQ_W-1:0] freq;
      dssr_out_t                outp;
      logic                     pi_active;
   } dssr_regs_t;

   dssr_regs_t state_reg;
   dssr_regs_t state_next;

   logic [FREQ_W-1:0]        upper_limit_frequency;
   logic [FREQ_W-1:0]        mag_ref;
   logic [FREQ_W-1:0]        target_mag;
   logic [FREQ_W+2:0]        torque_lim;
   logic signed [FREQ_W-1:0] target;
   logic                     in1;
   logic                     in2;
   logic [FREQ_W-1:0]        edge1;
   logic [FREQ_W-1:0]        edge2;
   logic [FREQ_W-1:0]        abs_freq;
   logic                     rate_tick;
   logic                     freeze;

   // Upper limit frequency follows the switching frequency code
   always_comb begin
      unique case (state_reg.cfg.switch_freq_sel)
         2'h0: upper_limit_frequency = UPPER_LIMIT_3K;
         2'h1: upper_limit_frequency = UPPER_LIMIT_6K;
         2'h2: upper_limit_frequency = UPPER_LIMIT_9K;
         2'h3: upper_limit_frequency = UPPER_LIMIT_12K;
      endcase
   end

   // Setpoint magnitude tested against both skip bands
   assign mag_ref  = freq_ref_in[FREQ_W-1] ? FREQ_W'(-freq_ref_in) : freq_ref_in;
   assign abs_freq = state_reg.freq[FREQ_W-1] ? FREQ_W'(-state_reg.freq) : state_reg.freq;

   // Two identical bands share one module
   dssr_skip_band #(.W(FREQ_W)) u_band1 (
      .mag_in     (mag_ref),
      .skip_in    (state_reg.cfg.skip_freq_1),
      .band_in    (state_reg.cfg.skip_band_1),
      .inside_out (in1),
      .edge_out   (edge1)
   );
   dssr_skip_band #(.W(FREQ_W)) u_band2 (
      .mag_in     (mag_ref),
      .skip_in    (state_reg.cfg.skip_freq_2),
      .band_in    (state_reg.cfg.skip_band_2),
      .inside_out (in2),
      .edge_out   (edge2)
   );

   // Target magnitude: torque mode runs up toward 120% of max, skip bands move the steady point
   always_comb begin
      torque_lim = (FREQ_W+3)'(max_freq_in) + (FREQ_W+3)'(max_freq_in / 16'h0005);
      if (torque_lim > (FREQ_W+3)'(upper_limit_frequency)) begin
         torque_lim = (FREQ_W+3)'(upper_limit_frequency);
      end
      if (state_reg.cfg.torque_control_select == CTRL_TORQUE) begin
         target_mag = torque_demand_high_in ? torque_lim[FREQ_W-1:0] : abs_freq;
      end else if (in1) begin
         target_mag = edge1;
      end else if (in2) begin
         target_mag = edge2;
      end else begin
         target_mag = mag_ref;
      end
      if (target_mag > upper_limit_frequency) begin
         target_mag = upper_limit_frequency;
      end
      target = freq_ref_in[FREQ_W-1] ? FREQ_W'(-target_mag) : target_mag;
      // Demand met in torque mode: hold the present frequency, its sign included
      if ((state_reg.cfg.torque_control_select == CTRL_TORQUE) && !torque_demand_high_in) begin
         target = state_reg.freq;
      end
   end

   assign rate_tick = (state_reg.rate_cnt == 32'(RATE_DIV - 1));
   // Standard mode holds the decel while the brake transistor conducts; fast mode never does
   assign freeze = (state_reg.cfg.decel_ramp_mode == DECEL_STANDARD) && brake_on_in;

   always_comb begin
      state_next = state_reg;
      if (cfg_we_in) begin
         state_next.cfg = cfg_in;
      end
      state_next.rate_cnt = rate_tick ? 32'h0 : state_reg.rate_cnt + 32'h1;
      state_next.outp.ramp_frozen = 1'b0;

      unique case (state_reg.st)
         DSSR_IDLE: begin
            state_next.freq = '0;
            if (run_in) begin
               state_next.st = DSSR_RUN;
            end
         end
         DSSR_RUN: begin
            // Ramp toward target; crossing a band just keeps ramping
            if (rate_tick) begin
               if (state_reg.freq < target) begin
                  state_next.freq = ((target - state_reg.freq) > $signed(accel_step_in))
                     ? FREQ_W'(state_reg.freq + $signed(accel_step_in)) : target;
               end else if (state_reg.freq > target) begin
                  if (freeze) begin
                     state_next.outp.ramp_frozen = 1'b1;
                  end else begin
                     state_next.freq = ((state_reg.freq - target) > $signed(decel_step_in))
                        ? FREQ_W'(state_reg.freq - $signed(decel_step_in)) : target;
                  end
               end
            end else begin
               state_next.outp.ramp_frozen = freeze && (state_reg.freq != target);
            end
            if (!run_in) begin
               unique case (state_reg.cfg.stop_sequence_mode)
                  STOP_COAST: begin
                     state_next.st    = DSSR_LOCK;
                     state_next.freq  = '0;
                     state_next.timer = 32'(HOLD_CYCLES);
                  end
                  STOP_TIMED_INJECT: begin
                     state_next.st    = DSSR_INJECT;
                     state_next.freq  = '0;
                     state_next.timer = inject_cycles_in;
                  end
                  default: begin
                     state_next.st = DSSR_DECEL;
                  end
               endcase
            end
         end
         DSSR_DECEL: begin
            // Run requests are ignored until the stop completes
            if (freeze) begin
               state_next.outp.ramp_frozen = 1'b1;
            end else if (rate_tick) begin
               if (abs_freq > decel_step_in) begin
                  state_next.freq = state_reg.freq[FREQ_W-1]
                     ? FREQ_W'(state_reg.freq + $signed(decel_step_in))
                     : FREQ_W'(state_reg.freq - $signed(decel_step_in));
               end else begin
                  state_next.freq  = '0;
                  state_next.timer = 32'(HOLD_CYCLES);
                  state_next.st = (state_reg.cfg.stop_sequence_mode == STOP_RAMP_INJECT)
                     ? DSSR_INJECT : DSSR_ZHOLD;
               end
            end
         end
         DSSR_ZHOLD: begin
            // Output held at zero for one second before it is released
            if (state_reg.timer <= 32'h1) begin
               state_next.st = DSSR_IDLE;
            end else begin
               state_next.timer = state_reg.timer - 32'h1;
            end
         end
         DSSR_INJECT: begin
            if (state_reg.timer <= 32'h1) begin
               state_next.st = DSSR_IDLE;
            end else begin
               state_next.timer = state_reg.timer - 32'h1;
            end
         end
         DSSR_LOCK: begin
            // Coast lockout: restart blocked until the full second has run
            if (state_reg.timer <= 32'h1) begin
               state_next.st = DSSR_IDLE;
            end else begin
               state_next.timer = state_reg.timer - 32'h1;
            end
         end
      endcase

      // Registered outputs follow the next state
      state_next.outp.freq          = state_next.freq;
      state_next.outp.output_enable = (state_next.st == DSSR_RUN) || (state_next.st == DSSR_DECEL)
                                    || (state_next.st == DSSR_ZHOLD)
                                    || (state_next.st == DSSR_INJECT);
      state_next.outp.dc_inject     = (state_next.st == DSSR_INJECT);
      state_next.outp.stop_busy     = (state_next.st == DSSR_DECEL) || (state_next.st == DSSR_ZHOLD)
                                    || (state_next.st == DSSR_INJECT)
                                    || (state_next.st == DSSR_LOCK);
      state_next.outp.reverse       = state_next.freq[FREQ_W-1];
      state_next.outp.regenerating  = (state_next.freq != '0)
                                    && (torque_negative_in != state_next.freq[FREQ_W-1]);
      state_next.outp.thermistor_input_mode =
         (state_next.cfg.analogue_input_mode == AIN_THERMISTOR);
      // Current loop always regulates in torque mode, else only once in limit
      state_next.pi_active = (state_next.cfg.torque_control_select == CTRL_TORQUE)
                           || current_limit_in;
   end

   // Single register bank for the whole state record
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg                           <= '0;
         state_reg.st                        <= DSSR_IDLE;
         state_reg.cfg.decel_ramp_mode       <= DECEL_MODE_RESET;
         state_reg.cfg.stop_sequence_mode    <= STOP_MODE_RESET;
         state_reg.cfg.torque_control_select <= CTRL_SEL_RESET;
         state_reg.cfg.analogue_input_mode   <= AIN_MODE_RESET;
         state_reg.cfg.skip_freq_1           <= SKIP_FREQ_RESET;
         state_reg.cfg.skip_freq_2           <= SKIP_FREQ_RESET;
         state_reg.cfg.skip_band_1           <= SKIP_BAND_RESET;
         state_reg.cfg.skip_band_2           <= SKIP_BAND_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign cfg_out       = state_reg.cfg;
   assign drive_out     = state_reg.outp;
   assign pi_active_out = state_reg.pi_active;
endmodule : dssr_sequencer
`default_nettype wire

// ### tb/dssr_seq_assertions.sv
// Port-level property checker for the drive stop and ramp sequencer
`timescale 1ns/1ps
`default_nettype none
module dssr_seq_assertions
   import dssr_pkg::*;
#(
   parameter int HOLD_CYCLES = HOLD_TICKS
) (
   input wire logic      clk_in,
   input wire logic      rst_b_in,
   input wire logic      run_in,
   input wire logic      brake_on_in,
   input wire logic      current_limit_in,
   input wire dssr_cfg_t cfg_out,
   input wire dssr_out_t drive_out,
   input wire logic      pi_active_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   logic [1:0] md;
   int         inj_cnt;
   int         off_cnt;
   int         zero_cnt;
   assign md = cfg_out.stop_sequence_mode;
   // Run lengths; off_cnt starts full so the first run after reset is legal
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         inj_cnt  <= 0;
         off_cnt  <= HOLD_CYCLES;
         zero_cnt <= 0;
      end else begin
         inj_cnt  <= drive_out.dc_inject ? inj_cnt + 1 : 0;
         zero_cnt <= (drive_out.output_enable && drive_out.stop_busy && drive_out.freq == 0
                      && !drive_out.dc_inject) ? zero_cnt + 1 : 0;
         if (drive_out.output_enable) begin
            off_cnt <= (md == STOP_COAST) ? 0 : HOLD_CYCLES;
         end else if (off_cnt < HOLD_CYCLES) begin
            off_cnt <= off_cnt + 1;
         end
      end
   end
   a_coast_disable: assert property (
      drive_out.output_enable && !drive_out.stop_busy && !run_in && md == STOP_COAST
      |=> !drive_out.output_enable && drive_out.stop_busy && drive_out.freq == 0)
      else $error("coast stop did not disable output at once");
   a_coast_lock: assert property (
      $rose(drive_out.output_enable) |-> off_cnt >= HOLD_CYCLES)
      else $error("output re-enabled too soon after coast");
   a_std_freeze: assert property (
      drive_out.stop_busy && drive_out.output_enable && brake_on_in && drive_out.freq != 0
      && !drive_out.dc_inject && cfg_out.decel_ramp_mode == DECEL_STANDARD
      && (md == STOP_RAMP || md == STOP_RAMP_INJECT)
      |=> drive_out.ramp_frozen && $stable(drive_out.freq))
      else $error("standard decel ramp moved while braking");
   a_fast_free: assert property (
      cfg_out.decel_ramp_mode == DECEL_FAST && $past(cfg_out.decel_ramp_mode) == DECEL_FAST
      |-> !drive_out.ramp_frozen)
      else $error("fast decel ramp was frozen");
   a_ramp_hold: assert property (
      $fell(drive_out.output_enable) && md == STOP_RAMP
      |-> zero_cnt inside {[HOLD_CYCLES:HOLD_CYCLES+2]})
      else $error("ramp stop zero hold has wrong length");
   a_inject_len: assert property (
      $fell(drive_out.dc_inject) && md == STOP_RAMP_INJECT |-> inj_cnt == HOLD_CYCLES)
      else $error("ramp stop injection has wrong length");
   a_timed_inject: assert property (
      drive_out.output_enable && !drive_out.stop_busy && !run_in && md == STOP_TIMED_INJECT
      |=> drive_out.dc_inject)
      else $error("timed injection did not start at once");
   a_pi_torque: assert property (
      cfg_out.torque_control_select && $past(cfg_out.torque_control_select) |-> pi_active_out)
      else $error("current loop idle in torque control");
   a_pi_idle: assert property (
      !cfg_out.torque_control_select && !$past(cfg_out.torque_control_select)
      && !current_limit_in && !$past(current_limit_in) |-> !pi_active_out)
      else $error("current loop active below limit");
   a_dir_sign: assert property (
      drive_out.reverse == drive_out.freq[FREQ_W-1]
      && (drive_out.freq != 0 || !drive_out.regenerating))
      else $error("direction or power flow disagrees with frequency");
   a_therm_follow: assert property (
      $stable(cfg_out.analogue_input_mode)
      |-> drive_out.thermistor_input_mode == cfg_out.analogue_input_mode)
      else $error("terminal mode does not follow setting");
endmodule : dssr_seq_assertions
bind dssr_sequencer dssr_seq_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
   .clk_in(clk_in), .rst_b_in(rst_b_in), .run_in(run_in), .brake_on_in(brake_on_in),
   .current_limit_in(current_limit_in), .cfg_out(cfg_out), .drive_out(drive_out),
   .pi_active_out(pi_active_out));
`default_nettype wire

// ### tb/dssr_brake_model.sv
// Braking transistor model that chops while the drive brakes a regenerating load
`timescale 1ns/1ps
`default_nettype none
module dssr_brake_model
   import dssr_pkg::*;
(
   input  wire logic      clk_in,
   input  wire logic      rst_b_in,
   input  wire dssr_out_t drive_in,
   input  wire logic      load_in,
   output logic           brake_on_out
);
   logic [2:0] phase_reg;
   // Link voltage rises during a stop; registered so it never races the sampling edge
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         phase_reg <= 3'h0;
      end else if (load_in && drive_in.output_enable && drive_in.stop_busy) begin
         phase_reg <= phase_reg + 3'h1;
      end else begin
         phase_reg <= 3'h0;
      end
   end
   // On for three cycles of eight, off again as the link drains
   assign brake_on_out = (phase_reg != 3'h0) && (phase_reg < 3'h4);
endmodule : dssr_brake_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking testbench for the drive stop and ramp sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dssr_pkg::*;
   localparam int HOLD_N = 50;
   logic clk_in, rst_b_in, cfg_we, run, brake_on, cur_lim, tq_hi, tq_neg, load, pi_act;
   logic signed [15:0] freq_ref;
   logic [15:0] max_freq, accel, decel;
   logic [31:0] inj_len;
   dssr_cfg_t   c, cfg_rd;
   dssr_out_t   drv;
   int          errors, tests_run, inj_n, fz_n, busy_n;
   logic [15:0] refs [5] = '{16'h0066, 16'h0060, 16'h0064, 16'h0069, 16'h00c3};
   logic [15:0] exps [5] = '{16'h0069, 16'h005f, 16'h005f, 16'h0069, 16'h00be};
   logic [15:0] up_lim [4] = '{16'h0960, 16'h12c0, 16'h1c20, 16'h2580};
   dssr_sequencer #(.HOLD_CYCLES(HOLD_N), .RATE_DIV(4)) DUT (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .cfg_in(c), .cfg_we_in(cfg_we), .run_in(run),
      .freq_ref_in(freq_ref), .max_freq_in(max_freq), .accel_step_in(accel),
      .decel_step_in(decel), .inject_cycles_in(inj_len), .brake_on_in(brake_on),
      .current_limit_in(cur_lim), .torque_demand_high_in(tq_hi),
      .torque_negative_in(tq_neg), .cfg_out(cfg_rd), .drive_out(drv), .pi_active_out(pi_act));
   dssr_brake_model u_brake (.clk_in(clk_in), .rst_b_in(rst_b_in), .drive_in(drv),
      .load_in(load), .brake_on_out(brake_on));
   // 100 ns clock
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   task automatic tick();
      @(posedge clk_in);
      #10;
   endtask : tick
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic write_cfg(input dssr_cfg_t v);
      c = v;
      cfg_we = 1'b1;
      tick();
      cfg_we = 1'b0;
      chk("cfg_readback", 32'h1, {31'h0, cfg_rd === v});
   endtask : write_cfg
   // Bounded wait, since a stuck ramp must not hang the run
   task automatic wait_freq(input logic [15:0] exp);
      for (int n = 0; n < 4000 && drv.freq !== exp; n++) tick();
      chk("freq", {16'h0, exp}, {16'h0, drv.freq});
   endtask : wait_freq
   task automatic wait_idle();
      inj_n  = 0;
      fz_n   = 0;
      busy_n = 0;
      for (int n = 0; n < 3000 && drv.stop_busy !== 1'b0; n++) begin
         busy_n++;
         inj_n += drv.dc_inject;
         fz_n  += drv.ramp_frozen;
         tick();
      end
      chk("stop_busy", 32'h0, drv.stop_busy);
   endtask : wait_idle
   task automatic results();
      if (errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   initial begin
      // A few thousand cycles are expected; this leaves ample margin
      #(20_000 * 100);
      errors++;
      results();
   end
   initial begin
      {rst_b_in, cfg_we, run, cur_lim, tq_hi, tq_neg, load} = 7'h00;
      freq_ref = 16'h0000;
      max_freq = 16'h2580;
      accel    = 16'h0005;
      decel    = 16'h0005;
      inj_len  = 32'h0000_0014;
      c        = '0;
      repeat (20) @(posedge clk_in);
      #10 rst_b_in = 1'b1;
      tick();
      chk("modes", 32'h4, {27'h0, cfg_rd[70:66]});
      chk("skip1", 32'h0000_0005, {cfg_rd.skip_freq_1, cfg_rd.skip_band_1});
      chk("skip2", 32'h0000_0005, {cfg_rd.skip_freq_2, cfg_rd.skip_band_2});
      chk("drive", 32'h0, {9'h0, drv});
      c = cfg_rd;
      c.switch_freq_sel = 2'h3;
      c.skip_freq_1 = 16'h0064;
      c.skip_freq_2 = 16'h00c8;
      c.skip_band_2 = 16'h000a;
      write_cfg(c);
      run = 1'b1;
      // Setpoints in both bands, and at the edge of and at the centre of the first band
      for (int i = 0; i < 5; i++) begin
         freq_ref = refs[i];
         wait_freq(exps[i]);
      end
      c.skip_freq_1 = 16'h0000;
      write_cfg(c);
      freq_ref = 16'h0064;
      wait_freq(16'h0064);
      // Stop modes 0..3 with standard decel, then ramp stop with fast decel
      for (int i = 0; i < 5; i++) begin
         c.stop_sequence_mode = (i == 4) ? 2'h1 : i[1:0];
         c.decel_ramp_mode = (i == 4);
         write_cfg(c);
         freq_ref = 16'h0032;
         wait_freq(16'h0032);
         run = 1'b0;
         load = 1'b1;
         tick();
         chk("dc_inject", i == 3, drv.dc_inject);
         if (i != 3) chk("enable", i != 0, drv.output_enable);
         if (i == 0) chk("coast_freq", 32'h0, {16'h0, drv.freq});
         run = 1'b1;
         wait_idle();
         chk("idle_enable", 32'h0, drv.output_enable);
         if (i == 0) chk("lock_len", HOLD_N, busy_n);
         chk("inject_len", (i == 2) ? HOLD_N : (i == 3) ? 20 : 0, inj_n);
         chk("frozen", (i == 1 || i == 2), fz_n != 0);
         load = 1'b0;
      end
      // Torque control toward 120 percent of maximum, then the limit per switching code
      c.torque_control_select = 1'b1;
      write_cfg(c);
      max_freq = 16'h0064;
      tq_hi = 1'b1;
      wait_freq(16'h0078);
      chk("pi_torque", 32'h1, pi_act);
      tq_neg = 1'b1;
      repeat (2) tick();
      chk("regen", 32'h1, drv.regenerating);
      tq_neg = 1'b0;
      tq_hi = 1'b0;
      repeat (20) tick();
      chk("motoring", 32'h0, drv.regenerating);
      chk("hold_freq", 32'h78, {16'h0, drv.freq});
      max_freq = 16'h2580;
      accel = 16'h0064;
      tq_hi = 1'b1;
      for (int s = 0; s < 4; s++) begin
         c.switch_freq_sel = s[1:0];
         write_cfg(c);
         wait_freq(up_lim[s]);
      end
      tq_hi = 1'b0;
      c.torque_control_select = 1'b0;
      c.analogue_input_mode = 1'b1;
      write_cfg(c);
      cur_lim = 1'b1;
      repeat (2) tick();
      chk("pi_limit", 32'h1, pi_act);
      chk("thermistor", 32'h1, drv.thermistor_input_mode);
      cur_lim = 1'b0;
      repeat (2) tick();
      chk("pi_idle", 32'h0, pi_act);
      // Negative setpoint: reverse rotation, positive torque now regenerates
      decel = 16'h0064;
      freq_ref = 16'hffce;
      wait_freq(16'hffce);
      chk("reverse", 32'h1, drv.reverse);
      chk("regen_rev", 32'h1, drv.regenerating);
      tq_neg = 1'b1;
      repeat (2) tick();
      chk("motoring_rev", 32'h0, drv.regenerating);
      run = 1'b0;
      results();
   end
endmodule : tb_top
`default_nettype wire
